// ==== rtl/bmx_pkg.sv ====
package bmx_pkg;

    // Special function register addresses
    localparam logic [7:0] SFR_SYSTEM_CONFIG   = 8'hFF;
    localparam logic [7:0] SFR_CODE_WAIT       = 8'h92;
    localparam logic [7:0] SFR_DATA_WAIT       = 8'h8E;
    localparam logic [7:0] SFR_STROBE_DURATION = 8'h9F;
    localparam logic [7:0] SFR_PHY_CONFIG      = 8'hFE;
    localparam logic [7:0] SFR_MAP_CONTROL     = 8'hFC;

    // Reset values
    localparam logic [7:0] SYSTEM_CONFIG_RST   = 8'h00;
    localparam logic [7:0] CODE_WAIT_RST       = 8'h07;
    localparam logic [7:0] DATA_WAIT_RST       = 8'h00;
    localparam logic [7:0] STROBE_DURATION_RST = 8'h00;
    localparam logic [7:0] PHY_CONFIG_RST      = 8'h00;

    // system_config fields
    localparam int SC_STUB_MAP_BIT   = 7;
    localparam int SC_PROG_EN_BIT    = 6;
    localparam int SC_MODE_HI        = 5;
    localparam int SC_MODE_LO        = 3;
    localparam int SC_FLASH_BUSY_BIT = 1;
    localparam int SC_BOOT_FLAG_BIT  = 0;
    localparam logic [7:0] SC_WRITE_MASK = 8'hF8;

    // phy_config fields
    localparam int PC_RESET_BIT    = 5;
    localparam int PC_OVERRIDE_BIT = 3;
    localparam int PC_MODE_HI      = 2;
    localparam int PC_MODE_LO      = 0;

    // map control: writing this bit switches to the application map
    localparam int MC_APP_MAP_BIT = 0;

    // External bus modes
    localparam logic [2:0] EXT_MUX16 = 3'b001;
    localparam logic [2:0] EXT_MUX24 = 3'b011;
    localparam logic [2:0] EXT_DIR16 = 3'b101;
    localparam logic [2:0] EXT_DIR24 = 3'b111;

    // Code space
    localparam logic [15:0] BOOT_ROM_LAST = 16'h07FF;
    localparam logic [15:0] STUB_FIRST    = 16'hFFF7;

    // Data space regions (upper address byte; DFL_LAST limits the low address byte)
    localparam logic [7:0] DSEG_RAM   = 8'h00;
    localparam logic [7:0] DSEG_NET   = 8'h01;
    localparam logic [7:0] DSEG_DFL   = 8'h02;
    localparam logic [7:0] DFL_LAST   = 8'hFE;

    typedef enum logic [1:0] {
        CSRC_BOOT  = 2'b00,
        CSRC_STUB  = 2'b01,
        CSRC_FLASH = 2'b10
    } bmx_csrc_t;

    typedef enum logic [2:0] {
        DSEL_RAM   = 3'b000,
        DSEL_FLASH = 3'b001,
        DSEL_NET   = 3'b010,
        DSEL_DFL   = 3'b011,
        DSEL_EXT   = 3'b100
    } bmx_dsel_t;

    typedef enum logic [1:0] {
        XS_IDLE = 2'b00,
        XS_ADDR = 2'b01,
        XS_WAIT = 2'b10,
        XS_DONE = 2'b11
    } bmx_xstate_t;

endpackage

// ==== rtl/bmx_top.sv ====
`timescale 1ns/10ps
module bmx_top
    import bmx_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Straps and package
    input  wire logic        BOOT_SELECT_PIN,
    input  wire logic        PKG_REDUCED,
    input  wire logic [2:0]  PHY_MODE_PINS,
    input  wire logic        MEM_LOCK,
    input  wire logic        FLASH_BUSY,
    // Special function register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WE,
    input  wire logic        SFR_RE,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    output logic             SFR_HIT,
    // Code fetch
    input  wire logic        CODE_REQ,
    input  wire logic [15:0] CODE_ADDR,
    output logic             CODE_RDY,
    output logic      [1:0]  CODE_SRC,
    // External move data access
    input  wire logic        DATA_REQ,
    input  wire logic        DATA_WE,
    input  wire logic [23:0] DATA_ADDR,
    input  wire logic [7:0]  DATA_WDATA,
    input  wire logic [7:0]  INT_RDATA,
    output logic             DATA_RDY,
    output logic      [2:0]  DATA_SEL,
    output logic      [7:0]  DATA_RDATA,
    // Outside access and debug
    input  wire logic        OUTSIDE_REQ,
    output logic             OUTSIDE_GRANT,
    output logic             DEBUG_EN,
    // PHY control
    output logic      [2:0]  PHY_MODE,
    output logic             PHY_RESET,
    // External bus strobes
    output logic             EXT_ALE,
    output logic             EXT_RD_N,
    output logic             EXT_WR_N,
    // Port pins
    input  wire logic [7:0]  P0_I,
    input  wire logic [7:0]  P1_I,
    input  wire logic [7:0]  P2_I,
    input  wire logic [7:0]  P3_I,
    output logic      [7:0]  P0_O,
    output logic      [7:0]  P1_O,
    output logic      [7:0]  P2_O,
    output logic      [7:0]  P3_O,
    output logic      [7:0]  P0_OE,
    output logic      [7:0]  P1_OE,
    output logic      [7:0]  P2_OE,
    output logic      [7:0]  P3_OE,
    // General purpose drive from the core
    input  wire logic [7:0]  GP0_O,
    input  wire logic [7:0]  GP1_O,
    input  wire logic [7:0]  GP2_O,
    input  wire logic [7:0]  GP3_O,
    input  wire logic [7:0]  GP0_OE,
    input  wire logic [7:0]  GP1_OE,
    input  wire logic [7:0]  GP2_OE,
    input  wire logic [7:0]  GP3_OE
);

    logic [1:0]  rst_sync_reg;
    logic        rst_n;

    logic [7:0]  sysconf_reg,  sysconf_next;
    logic [7:0]  cwait_reg,    cwait_next;
    logic [7:0]  dwait_reg,    dwait_next;
    logic [7:0]  strobe_reg,   strobe_next;
    logic [7:0]  phy_config_reg,  phy_config_next;
    logic        app_map_reg,  app_map_next;
    logic        stub_off_reg, stub_off_next;
    logic        boot_flag_reg, boot_flag_next;
    logic        boot_cap_reg, boot_cap_next;

    logic [7:0]  ccnt_reg,     ccnt_next;
    logic        crdy_reg,     crdy_next;
    logic [1:0]  csrc_reg,     csrc_next;

    bmx_xstate_t xstate_reg,   xstate_next;
    logic [7:0]  xcnt_reg,     xcnt_next;
    logic        xext_reg,     xext_next;
    logic        xwe_reg,      xwe_next;
    logic [23:0] xaddr_reg,    xaddr_next;
    logic [7:0]  xwdata_reg,   xwdata_next;
    logic [7:0]  rdata_reg,    rdata_next;
    logic [2:0]  dsel_reg,     dsel_next;

    logic [2:0]  ext_mode;
    logic        bus_on, bus_mux, bus_top;
    logic [2:0]  dsel_dec;

    // Two-stage release keeps reset removal clean
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Mode decode; reduced package has no bus at all
    assign ext_mode = sysconf_reg[SC_MODE_HI:SC_MODE_LO];
    assign bus_on   = !PKG_REDUCED && ext_mode[0];
    assign bus_mux  = bus_on && !ext_mode[2];
    assign bus_top  = bus_on && ext_mode[1];

    // Register file, strap capture and map state
    always_comb begin
        sysconf_next   = sysconf_reg;
        cwait_next     = cwait_reg;
        dwait_next     = dwait_reg;
        strobe_next    = strobe_reg;
        phy_config_next   = phy_config_reg;
        app_map_next   = app_map_reg;
        stub_off_next  = stub_off_reg;
        boot_flag_next = boot_flag_reg;
        boot_cap_next  = 1'b1;
        // Strap sampled once, first cycle after release
        if (!boot_cap_reg) begin
            boot_flag_next = BOOT_SELECT_PIN;
        end
        if (SFR_WE) begin
            if (SFR_ADDR == SFR_SYSTEM_CONFIG) begin
                sysconf_next = SFR_WDATA & SC_WRITE_MASK;
                if (!SFR_WDATA[SC_STUB_MAP_BIT]) begin
                    stub_off_next = 1'b1;
                end
            end else if (SFR_ADDR == SFR_CODE_WAIT) begin
                cwait_next = SFR_WDATA;
            end else if (SFR_ADDR == SFR_DATA_WAIT) begin
                dwait_next = SFR_WDATA;
            end else if (SFR_ADDR == SFR_STROBE_DURATION) begin
                strobe_next = SFR_WDATA;
            end else if (SFR_ADDR == SFR_PHY_CONFIG) begin
                phy_config_next = SFR_WDATA;
            end else if (SFR_ADDR == SFR_MAP_CONTROL) begin
                // One-way until reset: the stub cannot return to boot map
                if (SFR_WDATA[MC_APP_MAP_BIT]) begin
                    app_map_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            sysconf_reg   <= SYSTEM_CONFIG_RST;
            cwait_reg     <= CODE_WAIT_RST;
            dwait_reg     <= DATA_WAIT_RST;
            strobe_reg    <= STROBE_DURATION_RST;
            phy_config_reg   <= PHY_CONFIG_RST;
            app_map_reg   <= 1'b0;
            stub_off_reg  <= 1'b0;
            boot_flag_reg <= 1'b0;
            boot_cap_reg  <= 1'b0;
        end else begin
            sysconf_reg   <= sysconf_next;
            cwait_reg     <= cwait_next;
            dwait_reg     <= dwait_next;
            strobe_reg    <= strobe_next;
            phy_config_reg   <= phy_config_next;
            app_map_reg   <= app_map_next;
            stub_off_reg  <= stub_off_next;
            boot_flag_reg <= boot_flag_next;
            boot_cap_reg  <= boot_cap_next;
        end
    end

    // Register read mux
    always_comb begin
        SFR_RDATA = 8'h00;
        SFR_HIT   = 1'b1;
        if (SFR_ADDR == SFR_SYSTEM_CONFIG) begin
            SFR_RDATA                    = sysconf_reg;
            SFR_RDATA[SC_FLASH_BUSY_BIT] = FLASH_BUSY;
            SFR_RDATA[SC_BOOT_FLAG_BIT]  = boot_flag_reg;
        end else if (SFR_ADDR == SFR_CODE_WAIT) begin
            SFR_RDATA = cwait_reg;
        end else if (SFR_ADDR == SFR_DATA_WAIT) begin
            SFR_RDATA = dwait_reg;
        end else if (SFR_ADDR == SFR_STROBE_DURATION) begin
            SFR_RDATA = strobe_reg;
        end else if (SFR_ADDR == SFR_PHY_CONFIG) begin
            SFR_RDATA = phy_config_reg;
        end else if (SFR_ADDR == SFR_MAP_CONTROL) begin
            SFR_RDATA = {7'h00, app_map_reg};
        end else begin
            SFR_HIT = 1'b0;
        end
        if (!SFR_RE) begin
            SFR_HIT = 1'b0;
        end
    end

    // Code access: source select and wait-state counter
    always_comb begin
        ccnt_next = 8'h00;
        crdy_next = 1'b0;
        csrc_next = csrc_reg;
        if (!app_map_reg) begin
            // Boot map: code space answers from boot ROM image, except STUB_FIRST and up, which answers from the stub
            if (CODE_ADDR >= STUB_FIRST) begin
                csrc_next = CSRC_STUB;
            end else begin
                csrc_next = CSRC_BOOT;
            end
        end else if (CODE_ADDR >= STUB_FIRST && !stub_off_reg) begin
            csrc_next = CSRC_STUB;
        end else begin
            csrc_next = CSRC_FLASH;
        end
        if (CODE_REQ && !crdy_reg) begin
            if (ccnt_reg >= cwait_reg) begin
                crdy_next = 1'b1;
            end else begin
                ccnt_next = ccnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ccnt_reg <= 8'h00;
            crdy_reg <= 1'b0;
            csrc_reg <= CSRC_BOOT;
        end else begin
            ccnt_reg <= ccnt_next;
            crdy_reg <= crdy_next;
            csrc_reg <= csrc_next;
        end
    end

    // Data space decode
    always_comb begin
        dsel_dec = DSEL_EXT;
        if (DATA_ADDR[23:16] == DSEG_RAM) begin
            dsel_dec = app_map_reg ? DSEL_RAM : DSEL_FLASH;
        end else if (DATA_ADDR[23:16] == DSEG_NET) begin
            dsel_dec = DSEL_NET;
        end else if (DATA_ADDR[23:16] == DSEG_DFL && DATA_ADDR[15:8] == 8'h00 && DATA_ADDR[7:0] <= DFL_LAST) begin
            dsel_dec = DSEL_DFL;
        end
    end

    // Data access sequencer, internal and external
    always_comb begin
        xstate_next = xstate_reg;
        xcnt_next   = xcnt_reg;
        xext_next   = xext_reg;
        xwe_next    = xwe_reg;
        xaddr_next  = xaddr_reg;
        xwdata_next = xwdata_reg;
        rdata_next  = rdata_reg;
        dsel_next   = dsel_reg;
        case (xstate_reg)
            XS_IDLE: begin
                if (DATA_REQ) begin
                    // External move is the only path into data space
                    xaddr_next  = DATA_ADDR;
                    xwe_next    = DATA_WE;
                    xwdata_next = DATA_WDATA;
                    dsel_next   = dsel_dec;
                    xext_next   = (dsel_dec == DSEL_EXT) && bus_on;
                    xcnt_next   = 8'h00;
                    if ((dsel_dec == DSEL_EXT) && bus_mux) begin
                        xstate_next = XS_ADDR;
                    end else begin
                        xstate_next = XS_WAIT;
                    end
                end
            end
            XS_ADDR: begin
                if (xcnt_reg >= {6'h00, strobe_reg[1:0]}) begin
                    xcnt_next   = 8'h00;
                    xstate_next = XS_WAIT;
                end else begin
                    xcnt_next = xcnt_reg + 8'h01;
                end
            end
            XS_WAIT: begin
                if (xcnt_reg >= {5'h00, dwait_reg[2:0]}) begin
                    // Unmapped external space with no bus reads zero
                    if (xext_reg) begin
                        rdata_next = P0_I;
                    end else if (dsel_reg == DSEL_EXT) begin
                        rdata_next = 8'h00;
                    end else begin
                        rdata_next = INT_RDATA;
                    end
                    xstate_next = XS_DONE;
                end else begin
                    xcnt_next = xcnt_reg + 8'h01;
                end
            end
            XS_DONE: begin
                xext_next   = 1'b0;
                xstate_next = XS_IDLE;
            end
            default: begin
                xstate_next = XS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            xstate_reg <= XS_IDLE;
            xcnt_reg   <= 8'h00;
            xext_reg   <= 1'b0;
            xwe_reg    <= 1'b0;
            xaddr_reg  <= 24'h000000;
            xwdata_reg <= 8'h00;
            rdata_reg  <= 8'h00;
            dsel_reg   <= DSEL_RAM;
        end else begin
            xstate_reg <= xstate_next;
            xcnt_reg   <= xcnt_next;
            xext_reg   <= xext_next;
            xwe_reg    <= xwe_next;
            xaddr_reg  <= xaddr_next;
            xwdata_reg <= xwdata_next;
            rdata_reg  <= rdata_next;
            dsel_reg   <= dsel_next;
        end
    end

    // Pin assignment per mode; unused ports stay GPIO
    always_comb begin
        P0_O  = GP0_O;
        P0_OE = GP0_OE;
        P1_O  = GP1_O;
        P1_OE = GP1_OE;
        P2_O  = GP2_O;
        P2_OE = GP2_OE;
        P3_O  = GP3_O;
        P3_OE = GP3_OE;
        if (bus_on) begin
            P2_O  = xaddr_reg[15:8];
            P2_OE = 8'hFF;
            if (bus_mux) begin
                // Low address on P0 only during the strobe phase
                P0_O  = (xstate_reg == XS_ADDR) ? xaddr_reg[7:0] : xwdata_reg;
                P0_OE = ((xstate_reg == XS_ADDR) || (xext_reg && xwe_reg)) ? 8'hFF : 8'h00;
            end else begin
                P0_O  = xwdata_reg;
                P0_OE = (xext_reg && xwe_reg) ? 8'hFF : 8'h00;
                P1_O  = xaddr_reg[7:0];
                P1_OE = 8'hFF;
            end
            if (bus_top) begin
                P3_O  = xaddr_reg[23:16];
                P3_OE = 8'hFF;
            end
        end
    end

    assign EXT_ALE  = bus_mux && (xstate_reg == XS_ADDR);
    assign EXT_RD_N = !(xext_reg && !xwe_reg && (xstate_reg == XS_WAIT));
    assign EXT_WR_N = !(xext_reg && xwe_reg && (xstate_reg == XS_WAIT));

    assign CODE_RDY   = crdy_reg;
    assign CODE_SRC   = csrc_reg;
    assign DATA_RDY   = (xstate_reg == XS_DONE);
    assign DATA_SEL   = dsel_reg;
    assign DATA_RDATA = rdata_reg;

    // PHY mode from register only with override, never pins on small package
    assign PHY_MODE  = phy_config_reg[PC_OVERRIDE_BIT] ? phy_config_reg[PC_MODE_HI:PC_MODE_LO] :
                       (PKG_REDUCED ? 3'b000 : PHY_MODE_PINS);
    assign PHY_RESET = phy_config_reg[PC_RESET_BIT];

    assign OUTSIDE_GRANT = OUTSIDE_REQ && !MEM_LOCK;
    assign DEBUG_EN      = !MEM_LOCK;

endmodule

// ==== verif/bmx_top_sva.sv ====
`timescale 1ns/10ps
module bmx_chk
    import bmx_pkg::*;
(
    input wire logic        MCLK, RST_N, PKG_REDUCED, MEM_LOCK, SFR_WE, CODE_REQ, CODE_RDY,
    input wire logic        OUTSIDE_REQ, OUTSIDE_GRANT, DEBUG_EN, PHY_RESET, EXT_ALE, EXT_RD_N, EXT_WR_N,
    input wire logic [1:0]  CODE_SRC,
    input wire logic [2:0]  PHY_MODE, PHY_MODE_PINS,
    input wire logic [7:0]  SFR_ADDR, SFR_WDATA, P0_O, P0_OE, P1_O, P1_OE, P2_O, P3_O, P3_OE,
    input wire logic [7:0]  GP0_O, GP0_OE, GP1_OE, GP3_OE,
    input wire logic [15:0] CODE_ADDR,
    input wire logic [23:0] DATA_ADDR
);
    logic [7:0] cw_reg, phy_reg, cnt_reg;
    logic [2:0] em_reg;
    logic       app_reg, gone_reg;

    // Shadows rebuilt from the write strobes, and cnt_reg counting code wait cycles from CODE_REQ and CODE_RDY
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cw_reg   <= CODE_WAIT_RST;
            phy_reg  <= PHY_CONFIG_RST;
            em_reg   <= 3'h0;
            app_reg  <= 1'b0;
            gone_reg <= 1'b0;
            cnt_reg  <= 8'h00;
        end else begin
            cnt_reg <= (CODE_REQ && !CODE_RDY) ? cnt_reg + 8'h01 : 8'h00;
            if (SFR_WE) begin
                case (SFR_ADDR)
                    SFR_CODE_WAIT:   cw_reg <= SFR_WDATA;
                    SFR_PHY_CONFIG:  phy_reg <= SFR_WDATA;
                    SFR_MAP_CONTROL: app_reg <= app_reg | SFR_WDATA[0];
                    SFR_SYSTEM_CONFIG: begin
                        em_reg   <= SFR_WDATA[5:3];
                        gone_reg <= gone_reg | ~SFR_WDATA[7];
                    end
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    lock_grant_a: assert property (OUTSIDE_GRANT == (OUTSIDE_REQ && !MEM_LOCK))
        else $error("outside grant ignores lock");
    lock_debug_a: assert property (DEBUG_EN == !MEM_LOCK)
        else $error("debugger enable ignores lock");
    code_wait_a: assert property (CODE_RDY |-> cnt_reg == cw_reg + 8'h01)
        else $error("code ready at wrong count");
    boot_map_a: assert property (!app_reg && CODE_REQ && CODE_ADDR <= BOOT_ROM_LAST |=> CODE_SRC == CSRC_BOOT)
        else $error("boot map not fetching rom");
    app_flash_a: assert property (app_reg && CODE_REQ && (gone_reg || CODE_ADDR < STUB_FIRST)
        |=> CODE_SRC == CSRC_FLASH)
        else $error("app map not fetching flash");
    app_stub_a: assert property (app_reg && !gone_reg && CODE_REQ && CODE_ADDR >= STUB_FIRST
        |=> CODE_SRC == CSRC_STUB)
        else $error("stub not mapped");
    ale_mux_a: assert property (EXT_ALE |-> !em_reg[2] && em_reg[0] && P0_OE == 8'hFF
        && P0_O == DATA_ADDR[7:0] && P2_O == DATA_ADDR[15:8])
        else $error("latch strobe outside muxed mode or bad address");
    gpio_only_a: assert property (!em_reg[0] || PKG_REDUCED |-> !EXT_ALE && EXT_RD_N && EXT_WR_N
        && P0_O == GP0_O && P0_OE == GP0_OE && P3_OE == GP3_OE)
        else $error("bus activity without bus mode");
    mux16_gpio_a: assert property (em_reg == EXT_MUX16 |-> P1_OE == GP1_OE && P3_OE == GP3_OE)
        else $error("mode 001 took a gpio port");
    mux24_top_a: assert property (em_reg == EXT_MUX24 |-> P1_OE == GP1_OE
        && (!EXT_ALE || P3_O == DATA_ADDR[23:16]))
        else $error("mode 011 port use wrong");
    direct_addr_a: assert property (!EXT_RD_N && em_reg[2] |-> P1_OE == 8'hFF && P1_O == DATA_ADDR[7:0]
        && P2_O == DATA_ADDR[15:8] && P0_OE == 8'h00)
        else $error("direct read address wrong");
    dir16_gpio_a: assert property (em_reg == EXT_DIR16 |-> P3_OE == GP3_OE)
        else $error("mode 101 took port 3");
    dir24_top_a: assert property (em_reg == EXT_DIR24 && !EXT_WR_N |-> P3_OE == 8'hFF
        && P3_O == DATA_ADDR[23:16])
        else $error("mode 111 top address wrong");
    phy_sel_a: assert property (PHY_MODE == (phy_reg[PC_OVERRIDE_BIT] ? phy_reg[2:0]
        : (PKG_REDUCED ? 3'h0 : PHY_MODE_PINS)))
        else $error("phy mode source wrong");
    phy_rst_a: assert property (PHY_RESET == phy_reg[PC_RESET_BIT])
        else $error("phy reset not from register");
endmodule

bind bmx_top bmx_chk bmx_chk_i (.*);

// ==== verif/bmx_xmem.sv ====
`timescale 1ns/10ps
module bmx_xmem (
    // Bus side
    input wire logic       MCLK, ALE, RD_N, WR_N, MUXED,
    input wire logic [7:0] P0_O, P1_O,
    // Data returned on port 0
    output logic     [7:0] P0_DRV
);
    logic [7:0] mem [256];
    logic [7:0] adr;
    logic [7:0] last = 8'h00;
    wire  [7:0] a = MUXED ? adr : P1_O;

    always_ff @(posedge MCLK) begin
        if (ALE)
            adr <= P0_O;
        if (!WR_N)
            mem[a] <= P0_O;
        if (!RD_N)
            last <= mem[a];
    end
    // Released bus shows the inverse, never a stale copy
    assign P0_DRV = !RD_N ? mem[a] : ~last;
endmodule

// ==== verif/bmx_top_tb.sv ====
`timescale 1ns/10ps
module bmx_top_tb
    import bmx_pkg::*;
;
    logic        MCLK, RST_N, BOOT_SELECT_PIN, PKG_REDUCED, MEM_LOCK, FLASH_BUSY, SFR_WE, SFR_RE;
    logic        CODE_REQ, DATA_REQ, DATA_WE, OUTSIDE_REQ, CODE_RDY, DATA_RDY, SFR_HIT, muxed;
    logic        OUTSIDE_GRANT, DEBUG_EN, PHY_RESET, EXT_ALE, EXT_RD_N, EXT_WR_N;
    logic [1:0]  CODE_SRC;
    logic [2:0]  PHY_MODE_PINS, DATA_SEL, PHY_MODE;
    logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, DATA_WDATA, INT_RDATA, DATA_RDATA, xm_p0;
    logic [7:0]  P0_I, P1_I, P2_I, P3_I, P0_O, P1_O, P2_O, P3_O, P0_OE, P1_OE, P2_OE, P3_OE;
    logic [7:0]  GP0_O, GP1_O, GP2_O, GP3_O, GP0_OE, GP1_OE, GP2_OE, GP3_OE;
    logic [15:0] CODE_ADDR;
    logic [23:0] DATA_ADDR;
    int          n_mismatch = 0;
    int          n_compared = 0;

    bmx_top bmx_top_i (.*);
    bmx_xmem bmx_xmem_i (.MCLK(MCLK), .ALE(EXT_ALE), .RD_N(EXT_RD_N), .WR_N(EXT_WR_N), .MUXED(muxed),
                         .P0_O(P0_O), .P1_O(P1_O), .P0_DRV(xm_p0));
    assign P0_I = (P0_O & P0_OE) | (xm_p0 & ~P0_OE);
    assign P1_I = P1_O;
    assign P2_I = P2_O;
    assign P3_I = P3_O;

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    task automatic end_of_test;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic b);
        @(posedge MCLK);
        RST_N <= 1'b0;
        BOOT_SELECT_PIN <= b;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge MCLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WE <= 1'b1;
        @(posedge MCLK);
        SFR_WE <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        SFR_ADDR <= a;
        SFR_RE <= 1'b1;
        #1 chk(24'(SFR_RDATA), 24'(exp));
    endtask

    task automatic code(input logic [15:0] a, input logic [7:0] w, input logic [1:0] src);
        int n;
        @(posedge MCLK);
        CODE_ADDR <= a;
        CODE_REQ <= 1'b1;
        n = 0;
        do begin @(posedge MCLK); #1 n++; end while (!CODE_RDY && n < 20);
        if (n == 20) begin n_mismatch++; end_of_test; end
        chk(24'(n), 24'(w) + 24'h1);
        chk(24'(CODE_SRC), 24'(src));
        @(posedge MCLK);
        CODE_REQ <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic xfer(input logic we, input logic [23:0] a, input logic [7:0] d, input int cyc,
                        input logic [2:0] sel, input logic [7:0] exp);
        int n;
        @(posedge MCLK);
        DATA_REQ <= 1'b1;
        DATA_WE <= we;
        DATA_ADDR <= a;
        DATA_WDATA <= d;
        n = 0;
        do begin @(posedge MCLK); #1 n++; end while (!DATA_RDY && n < 40);
        if (n == 40) begin n_mismatch++; end_of_test; end
        if (cyc >= 0) chk(24'(n), 24'(cyc));
        chk(24'(DATA_SEL), 24'(sel));
        if (!we) chk(24'(DATA_RDATA), 24'(exp));
        @(posedge MCLK);
        DATA_REQ <= 1'b0;
    endtask

    task automatic s_regs;
        rdc(SFR_SYSTEM_CONFIG, 8'h00);
        rdc(SFR_CODE_WAIT, 8'h07);
        chk(24'(SFR_HIT), 24'h1);
        rdc(SFR_DATA_WAIT, 8'h00);
        rdc(SFR_STROBE_DURATION, 8'h00);
        rdc(SFR_PHY_CONFIG, 8'h00);
        rdc(8'hA1, 8'h00);
        chk(24'(SFR_HIT), 24'h0);
    endtask

    task automatic s_boot;
        do_reset(1'b1);
        FLASH_BUSY <= 1'b1;
        rdc(SFR_SYSTEM_CONFIG, 8'h03);
        wr(SFR_SYSTEM_CONFIG, 8'hFF);
        rdc(SFR_SYSTEM_CONFIG, 8'hFB);
        FLASH_BUSY <= 1'b0;
        do_reset(1'b0);
        rdc(SFR_SYSTEM_CONFIG, 8'h00);
    endtask

    task automatic s_map;
        code(16'h0100, 8'h07, CSRC_BOOT);
        for (int w = 3; w < 7; w++) begin
            wr(SFR_CODE_WAIT, 8'(w));
            code(16'h07FF, 8'(w), CSRC_BOOT);
        end
        xfer(1'b0, 24'h000010, 8'h00, 32'(DATA_WAIT_RST[2:0]) + 2, DSEL_FLASH, 8'h5C);
        wr(SFR_MAP_CONTROL, 8'h01);
        code(16'h0100, 8'h06, CSRC_FLASH);
        code(16'hFFF8, 8'h06, CSRC_STUB);
        wr(SFR_SYSTEM_CONFIG, 8'h00);
        code(16'hFFF8, 8'h06, CSRC_FLASH);
    endtask

    task automatic s_data;
        for (int d = 0; d < 8; d += 7) begin
            wr(SFR_DATA_WAIT, 8'(d));
            xfer(1'b0, 24'h000010, 8'h00, d + 2, DSEL_RAM, 8'h5C);
        end
        xfer(1'b0, 24'h010000, 8'h00, -1, DSEL_NET, 8'h5C);
        xfer(1'b0, 24'h0200FE, 8'h00, -1, DSEL_DFL, 8'h5C);
        xfer(1'b0, 24'h0200FF, 8'h00, -1, DSEL_EXT, 8'h00);
        #1 chk(24'(P0_OE), 24'(GP0_OE));
    endtask

    task automatic s_ext;
        logic [2:0]  md [4];
        logic [23:0] a;
        md = '{EXT_MUX16, EXT_MUX24, EXT_DIR16, EXT_DIR24};
        wr(SFR_STROBE_DURATION, 8'h01);
        wr(SFR_DATA_WAIT, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(SFR_SYSTEM_CONFIG, {2'b00, md[i], 3'b000});
            chk(24'(P2_OE), 24'hFF);
            muxed <= !md[i][2];
            a = 24'h123400 | 24'(i * 17);
            xfer(1'b1, a, 8'hA0 + 8'(i), md[i][2] ? 3 : 5, DSEL_EXT, 8'h00);
            xfer(1'b0, a, 8'h00, md[i][2] ? 3 : 5, DSEL_EXT, 8'hA0 + 8'(i));
        end
        wr(SFR_SYSTEM_CONFIG, 8'h00);
        chk(24'(P2_OE), 24'(GP2_OE));
    endtask

    task automatic s_phy;
        PHY_MODE_PINS <= 3'b101;
        wr(SFR_PHY_CONFIG, 8'h08);
        chk(24'(PHY_MODE), 24'h0);
        wr(SFR_PHY_CONFIG, 8'h0E);
        chk(24'(PHY_MODE), 24'h6);
        wr(SFR_PHY_CONFIG, 8'h28);
        chk(24'(PHY_RESET), 24'h1);
        wr(SFR_PHY_CONFIG, 8'h08);
        chk(24'(PHY_RESET), 24'h0);
        wr(SFR_PHY_CONFIG, 8'h00);
        chk(24'(PHY_MODE), 24'h5);
        PKG_REDUCED <= 1'b1;
        @(posedge MCLK);
        #1 chk(24'(PHY_MODE), 24'h0);
        PKG_REDUCED <= 1'b0;
    endtask

    task automatic s_lock;
        @(posedge MCLK);
        OUTSIDE_REQ <= 1'b1;
        MEM_LOCK <= 1'b1;
        #1 chk(24'({OUTSIDE_GRANT, DEBUG_EN}), 24'h0);
        @(posedge MCLK);
        MEM_LOCK <= 1'b0;
        #1 chk(24'({OUTSIDE_GRANT, DEBUG_EN}), 24'h3);
    endtask

    initial begin
        RST_N = 1'b0;
        {BOOT_SELECT_PIN, PKG_REDUCED, MEM_LOCK, FLASH_BUSY, SFR_WE, SFR_RE} = '0;
        {CODE_REQ, DATA_REQ, DATA_WE, OUTSIDE_REQ, muxed} = '0;
        {PHY_MODE_PINS, SFR_ADDR, SFR_WDATA, DATA_WDATA, CODE_ADDR, DATA_ADDR} = '0;
        INT_RDATA = 8'h5C;
        {GP0_O, GP1_O, GP2_O, GP3_O} = {8'hA5, 8'h5A, 8'hC3, 8'h3C};
        {GP0_OE, GP1_OE, GP2_OE, GP3_OE} = {8'h0F, 8'hF0, 8'h33, 8'hCC};
        do_reset(1'b0);
        s_regs;
        s_boot;
        s_map;
        s_data;
        s_ext;
        s_phy;
        s_lock;
        end_of_test;
    end
endmodule
